// ---- fpm_ctrl.sv ----
/*
 Front-panel menu controller: power-up sequence, menu walk, editing,
 save prompt, idle timeout, alarm. Assumes switch inputs are
 debounced one-cycle pulses and nvData holds the stored settings.
*/
`timescale 1ns/10ps
module fpm_ctrl
	import fpm_pkg::*;
#(
	parameter int IDLE_CYCLES = IDLE_CYC,
	parameter int SHOW_CYCLES = SHOW_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 arst_n,
	input  wire logic                 swStep,
	input  wire logic                 swLeft,
	input  wire logic                 swRight,
	input  wire logic                 swUp,
	input  wire logic                 swDown,
	input  wire logic                 optFine,
	input  wire logic                 optRef,
	input  wire logic                 optSerial,
	input  wire logic                 optTemp,
	input  wire logic                 optAmp,
	input  wire logic [2:0]           pllUnlock,
	input  wire logic [SET_W-1:0]     nvData,
	output logic [SET_W-1:0]          nvWrData,
	output logic                      nvWrite,
	output logic [2:0]                dispMode,
	output logic [3:0]                menuNum,
	output logic [2:0]                cursorPos,
	output logic                      saveYes,
	output logic [SET_W-1:0]          liveSet,
	output logic                      rfMute,
	output logic                      alarm
);
	import fpm_pkg::*;

	typedef struct packed {
		fpm_mode_t   mode;
		logic [3:0]  menu;
		logic [2:0]  cur;
		logic        yes;
		logic [31:0] tmr;
		fpm_set_t    saved;
		fpm_set_t    edit;
		fpm_set_t    live;
		logic        wr;
		logic        fmute;
		logic        alarm;
		logic        rfm;
	} fpm_st_t;

	fpm_st_t st_reg, st_next;
	logic signed [15:0] stepIn, stepOut;
	logic               act, vert;

	function automatic logic menuOn(input logic [3:0] m, input logic r,
			input logic q, input logic t, input logic v);
		case (m)
			4'h6, 4'h7: menuOn = r;
			4'h8, 4'h9: menuOn = q;
			4'hA:       menuOn = t;
			4'hB:       menuOn = v;
			default:    menuOn = 1'b1;
		endcase
	endfunction : menuOn

	function automatic logic outOk(input logic signed [7:0] l,
			input logic signed [11:0] g, input logic f);
		logic signed [11:0] o;
		o = (f ? g : 12'(g * 10)) + 12'(l * 10);
		outOk = (o >= OUT_MIN) && (o <= OUT_MAX);
	endfunction : outOk

	assign act  = swStep | swLeft | swRight | swUp | swDown;
	assign vert = swUp | swDown;

	always_comb begin
		case (st_reg.menu)
			4'h1:    stepIn = 16'($signed({1'b0, st_reg.edit.freq}));
			4'h2:    stepIn = 16'(st_reg.edit.lvl);
			default: stepIn = 16'(st_reg.edit.gain);
		endcase
	end

	fpm_step u_step (
		.value  (stepIn),
		.cursor (st_reg.cur),
		.up     (swUp),
		.result (stepOut)
	);

	always_comb begin
		logic [3:0] nm;
		fpm_set_t   e;
		nm = 4'h0;
		e = st_reg.edit;
		st_next = st_reg;
		st_next.wr = 1'b0;
		st_next.alarm = |pllUnlock;
		case (st_reg.mode)
			FPM_SEGS, FPM_VER: begin
				if (st_reg.tmr >= 32'(SHOW_CYCLES - 1)) begin
					st_next.tmr = '0;
					st_next.mode = (st_reg.mode == FPM_SEGS) ?
						FPM_VER : FPM_NORMAL;
					st_next.saved = nvData;
					st_next.edit = nvData;
					st_next.live = nvData;
				end else
					st_next.tmr = st_reg.tmr + 32'h1;
			end
			FPM_NORMAL: begin
				st_next.tmr = '0;
				if (swStep) begin
					st_next.mode = FPM_MENU;
					st_next.menu = 4'h1;
					st_next.cur = '0;
					st_next.edit = st_reg.saved;
				end
			end
			FPM_MENU, FPM_SAVE: begin
				st_next.tmr = act ? '0 : st_reg.tmr + 32'h1;
				if (!act && st_reg.tmr >= 32'(IDLE_CYCLES - 1)) begin
					st_next.mode = FPM_NORMAL;
					st_next.edit = st_reg.saved;
					st_next.live = st_reg.saved;
					st_next.fmute = 1'b0;
				end else if (st_reg.mode == FPM_SAVE) begin
					if (vert)
						st_next.yes = ~st_reg.yes;
					if (swStep) begin
						st_next.mode = FPM_NORMAL;
						st_next.fmute = 1'b0;
						if (st_reg.yes) begin
							st_next.saved = st_reg.edit;
							st_next.live = st_reg.edit;
							st_next.wr = 1'b1;
						end else begin
							st_next.edit = st_reg.saved;
							st_next.live = st_reg.saved;
						end
					end
				end else if (swStep) begin
					if (st_reg.cur == 3'h7) begin
						st_next.mode = FPM_SAVE;
						st_next.yes = 1'b0;
					end else begin
						nm = st_reg.menu + 4'h1;
						while_loop: for (int i = 0; i < 6; i++)
							if (nm <= 4'(LAST_MENU) && !menuOn(nm, optRef,
									optSerial, optTemp, optAmp))
								nm = nm + 4'h1;
						if (nm > 4'(LAST_MENU)) begin
							st_next.mode = FPM_SAVE;
							st_next.yes = 1'b0;
						end else
							st_next.menu = nm;
						st_next.cur = '0;
					end
				end else if (swLeft || swRight) begin
					if (swLeft)
						st_next.cur = (st_reg.cur == CUR_MAX) ? 3'h7 :
							st_reg.cur + 3'h1;
					else
						st_next.cur = (st_reg.cur == 3'h7) ? CUR_MAX :
							(st_reg.cur == 3'h0 ? 3'h0 : st_reg.cur - 3'h1);
				end else if (vert && st_reg.cur != 3'h7) begin
					case (st_reg.menu)
						4'h1: if (stepOut >= 16'(FREQ_MIN) &&
								stepOut <= 16'(FREQ_MAX)) begin
							e.freq = stepOut[11:0];
							st_next.fmute = 1'b1;
						end
						4'h2: if (stepOut >= 16'(LVL_MIN) &&
								stepOut <= 16'(LVL_MAX))
							e.lvl = stepOut[7:0];
						4'h3: if (stepOut >= 16'(optFine ? GAIN_MIN :
								GAIN_MIN / 10) && stepOut <= 16'(optFine ?
								GAIN_MAX : GAIN_MAX / 10))
							e.gain = stepOut[11:0];
						4'h4: e.mute = ~e.mute;
						4'h5: e.remote = ~e.remote;
						4'h6: e.extRef = ~e.extRef;
						4'h7: e.refIns = ~e.refIns;
						4'h8: e.rs485 = ~e.rs485;
						4'h9: e.addr = e.addr + 5'h1;
						default: ;
					endcase
					if (outOk(e.lvl, e.gain, optFine)) begin
						st_next.edit = e;
						st_next.live.lvl = e.lvl;
						st_next.live.gain = e.gain;
					end
				end
			end
			default: st_next.mode = FPM_SEGS;
		endcase
		// Carrier mute held in its own flop
		st_next.rfm = st_next.fmute | st_next.live.mute;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
			st_reg.mode <= FPM_SEGS;
		end else
			st_reg <= st_next;
	end

	always_comb begin
		nvWrData  = st_reg.saved;
		nvWrite   = st_reg.wr;
		dispMode  = st_reg.mode;
		menuNum   = st_reg.menu;
		cursorPos = st_reg.cur;
		saveYes   = st_reg.yes;
		liveSet   = st_reg.live;
		rfMute    = st_reg.rfm;
		alarm     = st_reg.alarm;
	end

	property p_alarm;
		@(posedge clk) disable iff (!arst_n)
		|pllUnlock |=> alarm;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm missed");

	sequence s_saveYes;
		st_reg.mode == FPM_SAVE && st_reg.yes && swStep && act;
	endsequence
	property p_commit;
		@(posedge clk) disable iff (!arst_n)
		(s_saveYes and (st_reg.tmr < 32'(IDLE_CYCLES - 1))) |=> nvWrite;
	endproperty
	a_commit: assert property (p_commit) else $error("no store");

	property p_noWr;
		@(posedge clk) disable iff (!arst_n)
		nvWrite |-> $past(st_reg.mode) == FPM_SAVE;
	endproperty
	a_noWr: assert property (p_noWr) else $error("stray store");

	property p_lvl;
		@(posedge clk) disable iff (!arst_n)
		st_reg.mode == FPM_MENU |-> st_reg.edit.lvl >= LVL_MIN &&
			st_reg.edit.lvl <= LVL_MAX;
	endproperty
	a_lvl: assert property (p_lvl) else $error("level range");

	property p_fmute;
		@(posedge clk) disable iff (!arst_n)
		st_reg.edit.freq != $past(st_reg.edit.freq) &&
			st_reg.mode == FPM_MENU |-> rfMute;
	endproperty
	a_fmute: assert property (p_fmute) else $error("no mute");

	property p_idle;
		@(posedge clk) disable iff (!arst_n)
		st_reg.tmr == 32'(IDLE_CYCLES - 1) && st_reg.mode == FPM_MENU
			&& !act |=> st_reg.mode == FPM_NORMAL;
	endproperty
	a_idle: assert property (p_idle) else $error("no timeout");

	property p_tmr;
		@(posedge clk) disable iff (!arst_n)
		act && st_reg.mode == FPM_MENU |=> st_reg.tmr == 32'h0;
	endproperty
	a_tmr: assert property (p_tmr) else $error("timer kept");

	property p_hold;
		@(posedge clk) disable iff (!arst_n)
		st_reg.mode == FPM_MENU |-> liveSet[SET_W-1 -: 12] ==
			st_reg.saved.freq;
	endproperty
	a_hold: assert property (p_hold) else $error("freq early");
endmodule : fpm_ctrl

// ---- fpm_pkg.sv ----
/*
 Constants and types of the front-panel menu controller.
 Assumes a 125 MHz clock and debounced one-cycle switch pulses.
*/
package fpm_pkg;
	localparam int CLK_MHZ       = 125;
	localparam int IDLE_S        = 12;
	localparam int IDLE_CYC      = IDLE_S * CLK_MHZ * 1000000;
	localparam int SHOW_MS       = 1000;
	localparam int SHOW_CYC      = SHOW_MS * CLK_MHZ * 1000;
	localparam int LAST_MENU     = 11;
	localparam logic [11:0] FREQ_MIN = 12'h3B6;
	localparam logic [11:0] FREQ_MAX = 12'h866;
	localparam logic signed [7:0] LVL_MIN  = -8'sh28;
	localparam logic signed [7:0] LVL_MAX  = -8'sh0A;
	localparam logic signed [11:0] GAIN_MIN = -12'sh064;
	localparam logic signed [11:0] GAIN_MAX = 12'sh12C;
	localparam logic signed [11:0] OUT_MIN  = -12'sh0C8;
	localparam logic signed [11:0] OUT_MAX  = 12'sh000;
	localparam logic [2:0]  CUR_MAX  = 3'h3;
	// Freq, level, gain, five on/off flags, address
	localparam int SET_W = 12 + 8 + 12 + 5 + 5;

	typedef enum logic [2:0] {
		FPM_SEGS, FPM_VER, FPM_NORMAL, FPM_MENU, FPM_SAVE
	} fpm_mode_t;

	typedef struct packed {
		logic [11:0]        freq;
		logic signed [7:0]  lvl;
		logic signed [11:0] gain;
		logic               mute;
		logic               remote;
		logic               extRef;
		logic               refIns;
		logic               rs485;
		logic [4:0]         addr;
	} fpm_set_t;
endpackage : fpm_pkg

// ---- fpm_step.sv ----
/*
 Decimal step of one digit of a settings value.
 Assumes the caller drops a result outside its own range.
*/
`timescale 1ns/10ps
module fpm_step (
	input  wire logic signed [15:0] value,
	input  wire logic [2:0]         cursor,
	input  wire logic               up,
	output logic signed [15:0]      result
);
	logic signed [15:0] w;
	always_comb begin
		case (cursor)
			3'h0:    w = 16'sh0001;
			3'h1:    w = 16'sh000A;
			3'h2:    w = 16'sh0064;
			default: w = 16'sh03E8;
		endcase
		result = up ? value + w : value - w;
	end
endmodule : fpm_step

// ---- fpm_oper.sv ----
/*
 Operator model: turns a key request into a one-cycle switch pulse.
 Assumes requests change just after a rising clock edge.
*/
`timescale 1ns/10ps
module fpm_oper (
	input  wire logic       clk,
	input  wire logic       fire,
	input  wire logic [2:0] key,
	output logic            swStep,
	output logic            swLeft,
	output logic            swRight,
	output logic            swUp,
	output logic            swDown
);
	logic       fireReg = 1'b0;
	logic [2:0] keyReg  = 3'h0;

	always @(posedge clk) begin
		fireReg <= fire;
		keyReg  <= key;
	end
	// One switch per cycle, one-cycle pulse
	assign swStep  = fireReg && keyReg == 3'h0;
	assign swLeft  = fireReg && keyReg == 3'h1;
	assign swRight = fireReg && keyReg == 3'h2;
	assign swUp    = fireReg && keyReg == 3'h3;
	assign swDown  = fireReg && keyReg == 3'h4;
endmodule : fpm_oper

// ---- front_panel_menu_controller_bench.sv ----
/*
 Self-checking bench of the menu controller.
 Assumes short idle and show counts and a storage model in the bench.
*/
`timescale 1ns/10ps
module front_panel_menu_controller_bench;
	import fpm_pkg::*;
	logic       clk = 1'b0, arst_n = 1'b0, fire = 1'b0;
	logic [2:0] key = 3'h0, pllUnlock = 3'h0;
	logic [4:0] opts = 5'h1F;
	logic       swStep, swLeft, swRight, swUp, swDown, nvWrite;
	logic       saveYes, rfMute, alarm;
	logic [2:0] dispMode, cursorPos;
	logic [3:0] menuNum;
	fpm_set_t   nv, wr, live, s;
	int         fails = 0, num_checks = 0, n;

	initial forever #4 clk = ~clk;
	// Nonvolatile store
	always @(posedge clk) if (nvWrite === 1'b1) nv <= wr;

	fpm_oper i_fpm_oper (.clk(clk), .fire(fire), .key(key),
		.swStep(swStep), .swLeft(swLeft), .swRight(swRight),
		.swUp(swUp), .swDown(swDown));
	fpm_ctrl #(.IDLE_CYCLES(200), .SHOW_CYCLES(10)) i_fpm_ctrl (
		.clk(clk), .arst_n(arst_n), .swStep(swStep), .swLeft(swLeft),
		.swRight(swRight), .swUp(swUp), .swDown(swDown),
		.optFine(opts[0]), .optRef(opts[1]), .optSerial(opts[2]),
		.optTemp(opts[3]), .optAmp(opts[4]), .pllUnlock(pllUnlock),
		.nvData(nv), .nvWrData(wr), .nvWrite(nvWrite),
		.dispMode(dispMode), .menuNum(menuNum), .cursorPos(cursorPos),
		.saveYes(saveYes), .liveSet(live), .rfMute(rfMute), .alarm(alarm));

	task automatic wrap_up;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic press(input logic [2:0] k);
		@(posedge clk) #1 key = k;
		fire = 1'b1;
		@(posedge clk) #1 fire = 1'b0;
		@(posedge clk) #1;
	endtask : press

	task automatic wait_mode(input logic [2:0] m, input int lim);
		int c;
		c = 0;
		while (dispMode !== m && c < lim) begin
			@(posedge clk) #1;
			c++;
		end
		if (c >= lim) begin
			fails++;
			$display("CHECK FAILED wait mode exp %h seen %h", m, dispMode);
			wrap_up();
		end
	endtask : wait_mode

	function automatic bit shown(input int m);
		case (m)
			6, 7: return opts[1];
			8, 9: return opts[2];
			10: return opts[3];
			11: return opts[4];
			default: return 1'b1;
		endcase
	endfunction : shown

	initial begin
		n = $urandom(14385);
		opts = 5'($urandom());
		nv = '0;
		nv.freq = 12'h3E8;
		nv.lvl = -8'sd20;
		nv.mute = 1'b1;
		repeat (5) @(posedge clk);
		chk("segs", dispMode, FPM_SEGS);
		#1 arst_n = 1'b1;
		wait_mode(FPM_VER, 20);
		wait_mode(FPM_NORMAL, 20);
		chk("restore", live, nv);
		$display("test power-up done");
		for (int m = 1; m <= 11; m++) begin
			if (shown(m)) begin
				press(3'h0);
				chk("menu", menuNum, m);
			end
		end
		press(3'h0);
		chk("save", dispMode, FPM_SAVE);
		press(3'h0);
		chk("no write", nvWrite, 1'b0);
		chk("kept", live, nv);
		$display("test menu walk done");
		s = nv;
		s.mute = ~s.mute;
		repeat (4) press(3'h0);
		chk("menu4", menuNum, 4'h4);
		press(3'h3);
		press(3'h4);
		press(3'h4);
		repeat (4) press(3'h1);
		chk("cursor", cursorPos, 3'h7);
		press(3'h0);
		press(3'h3);
		chk("yes", saveYes, 1'b1);
		press(3'h0);
		chk("write", nvWrite, 1'b1);
		chk("stored", wr, s);
		$display("test mute save done");
		press(3'h0);
		chk("rf quiet", rfMute, 1'b0);
		press(3'h3);
		chk("rf mute", rfMute, 1'b1);
		chk("freq held", live.freq, nv.freq);
		press(3'h0);
		press(3'h4);
		chk("lvl low", live.lvl, -8'sd20);
		repeat (15) press(3'h3);
		chk("lvl high", live.lvl, -8'sd10);
		press(3'h0);
		press(3'h3);
		chk("gain step", live.gain, 64'h1);
		press(3'h1);
		press(3'h3);
		chk("gain cap", live.gain, 64'(opts[0] ? 11 : 1));
		repeat (150) @(posedge clk) #1;
		chk("still menu", dispMode, FPM_MENU);
		wait_mode(FPM_NORMAL, 100);
		chk("discard", live, nv);
		$display("test idle done");
		pllUnlock = 3'h1 << ($urandom() % 3);
		repeat (2) @(posedge clk) #1;
		chk("alarm on", alarm, 1'b1);
		pllUnlock = 3'h0;
		repeat (2) @(posedge clk) #1;
		chk("alarm off", alarm, 1'b0);
		$display("test alarm done");
		arst_n = 1'b0;
		repeat (2) @(posedge clk) #1;
		chk("reset mode", dispMode, FPM_SEGS);
		chk("reset store", nvWrite, 1'b0);
		arst_n = 1'b1;
		wait_mode(FPM_VER, 20);
		wait_mode(FPM_NORMAL, 20);
		chk("power cycle", live, nv);
		$display("test power cycle done");
		wrap_up();
	end
endmodule : front_panel_menu_controller_bench
